// ===== mnpb_defs.svh
`ifndef MNPB_DEFS_SVH
`define MNPB_DEFS_SVH

// clock period of CLK
`define MNPB_CLK_PERIOD_NS 4

// lowest and highest supported line frequency
`define MNPB_LINE_HZ_MIN 45
`define MNPB_LINE_HZ_MAX 55

// observation window: one line period at the lowest frequency, rounded up
`define MNPB_WINDOW_CYC \
	((1000000000 + `MNPB_LINE_HZ_MIN * `MNPB_CLK_PERIOD_NS - 1) / \
	(`MNPB_LINE_HZ_MIN * `MNPB_CLK_PERIOD_NS))

// calibration pulse width
`define MNPB_CF_WIDTH_MS 90
`define MNPB_CF_WIDTH_CYC ((`MNPB_CF_WIDTH_MS * 1000000) / `MNPB_CLK_PERIOD_NS)

// voltage channel full scale code and missing-neutral threshold
`define MNPB_FULL_SCALE 32767
`define MNPB_PEAK_PCT 9

// gain level scaling (about 0.785): rectified current times this level
// bills like a sine of that peak on the voltage channel
`define MNPB_GAIN_NUM 804
`define MNPB_GAIN_SHIFT 10

// accumulator threshold for one calibration pulse
`define MNPB_CF_THRESH 48'h0000_4000_0000

// calibration-to-billing ratios
`define MNPB_RATIO_2048 12'h800
`define MNPB_RATIO_128 12'h080
`define MNPB_RATIO_64 12'h040
`define MNPB_RATIO_32 12'h020
`define MNPB_RATIO_16 12'h010

// accumulator shifts for the calibration scaling
`define MNPB_SHIFT_LOW 4'h0
`define MNPB_SHIFT_HIGH 4'h1
`define MNPB_SHIFT_FAST 4'h8

// reset values
`define MNPB_SEL_RST 3'h0
`define MNPB_REVERSE_POWER_INDICATOR_RST 1'b0

`endif

// ===== mnpb_pkg.sv
package mnpb_pkg;

	// one-hot billing mode
	typedef enum logic [1:0] {
		MNPB_NORMAL  = 2'b01,
		MNPB_MISSING = 2'b10
	} mnpb_mode_e;

	// frequency and scale select pins
	typedef struct packed {
		logic calibration_scale_select;
		logic freq_select_hi;
		logic freq_select_lo;
	} mnpb_sel_s;

	// one converted sample set
	typedef struct packed {
		logic signed [15:0] voltage_channel;
		logic signed [15:0] current_channel;
		logic [14:0]        missing_neutral_gain_in;
	} mnpb_sample_s;

endpackage

// ===== mnpb_pulse_shaper.sv
`timescale 1ns/1ps
`include "mnpb_defs.svh"

module mnpb_pulse_shaper #(
	parameter int unsigned MAX_WIDTH_CYC = `MNPB_CF_WIDTH_CYC
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic trig,
	output logic      pulse_q
);

	logic [31:0] period_q;
	logic [31:0] period_d;
	logic [31:0] left_q;
	logic [31:0] left_d;
	logic        pulse_d;
	logic [31:0] half;

	// width is the full pulse, or half the period once the period gets short
	always_comb begin
		half = period_q >> 1;
		period_d = period_q;
		left_d = left_q;
		if (period_q != 32'hffff_ffff) begin
			period_d = period_q + 32'h1;
		end
		if (left_q != 32'h0) begin
			left_d = left_q - 32'h1;
		end
		if (trig) begin
			period_d = 32'h1;
			if (half < MAX_WIDTH_CYC) begin
				left_d = (half == 32'h0) ? 32'h1 : half;
			end else begin
				left_d = MAX_WIDTH_CYC;
			end
		end
		pulse_d = (left_d != 32'h0);
	end

	// registers; period starts saturated so the first pulse is full width
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			period_q <= 32'hffff_ffff;
			left_q   <= 32'h0;
			pulse_q  <= 1'b0;
		end else begin
			period_q <= period_d;
			left_q   <= left_d;
			pulse_q  <= pulse_d;
		end
	end

endmodule

// ===== mnpb_core.sv
`timescale 1ns/1ps
`include "mnpb_defs.svh"
// Contract
// - enter missing-neutral when peak below 9%
// - enter missing-neutral when no zero crossings
// - leave only with peak above 9% and crossings
// - missing-neutral bills from active current level
// - keep pulsing on all outputs, ampere-hour basis
// - wiring alarm high during missing-neutral billing
// - gain 330 mV matches 330 mV peak sine
// - pulse rate linear in gain, zero to double
// - billing rate follows current times gain formula
// - four base frequencies from two select inputs
// - scale 0 with selects 11 gives 2048x
// - full-scale inputs give about 5.5 kHz calibration
// - detection windows cover 45 to 55 Hz
// - calibration pulse 90 ms, half period below 180 ms
// - reverse indicator follows sign, changes on calibration pulse
module mnpb_core #(
	parameter int unsigned WINDOW_CYC   = `MNPB_WINDOW_CYC,
	parameter int unsigned CF_WIDTH_CYC = `MNPB_CF_WIDTH_CYC,
	parameter logic [47:0] CF_THRESH    = `MNPB_CF_THRESH
) (
	input  wire logic                  CLK,
	input  wire logic                  SYS_RST,
	input  wire logic                  SAMPLE_VALID,
	input  wire mnpb_pkg::mnpb_sample_s SAMPLE,
	input  wire mnpb_pkg::mnpb_sel_s    SELECT,
	output logic                       CALIBRATION_PULSE_OUT,
	output logic                       BILLING_PULSE_A,
	output logic                       BILLING_PULSE_B,
	output logic                       REVERSE_POWER_INDICATOR,
	output logic                       WIRING_ALARM
);
	import mnpb_pkg::*;

	localparam logic [15:0] PEAK_THR = 16'((`MNPB_FULL_SCALE * `MNPB_PEAK_PCT) / 100);
	localparam logic [31:0] WIN_LAST = 32'(WINDOW_CYC - 1);
	localparam logic signed [47:0] THR_POS = CF_THRESH;

	// magnitude of a signed sample, -32768 gives 32768
	function automatic logic [15:0] mag16(input logic signed [15:0] x);
		logic [15:0] r;
		r = x[15] ? 16'(-x) : 16'(x);
		return r;
	endfunction

	// calibration-to-billing ratio from scale and frequency selects
	function automatic logic [11:0] cf_ratio(input mnpb_sel_s s);
		logic [11:0] r;
		unique case ({s.calibration_scale_select, s.freq_select_hi, s.freq_select_lo})
			3'b100: r = `MNPB_RATIO_128;
			3'b000: r = `MNPB_RATIO_64;
			3'b101: r = `MNPB_RATIO_64;
			3'b001: r = `MNPB_RATIO_32;
			3'b110: r = `MNPB_RATIO_32;
			3'b010: r = `MNPB_RATIO_16;
			3'b111: r = `MNPB_RATIO_16;
			default: r = `MNPB_RATIO_2048; // 3'b011
		endcase
		return r;
	endfunction

	// accumulator shift: calibration rate is halved with scale 0, fast with 011
	function automatic logic [3:0] cf_shift(input mnpb_sel_s s);
		logic [3:0] r;
		if (!s.calibration_scale_select && s.freq_select_hi && s.freq_select_lo) begin
			r = `MNPB_SHIFT_FAST;
		end else if (s.calibration_scale_select) begin
			r = `MNPB_SHIFT_HIGH;
		end else begin
			r = `MNPB_SHIFT_LOW;
		end
		return r;
	endfunction

	// ---------------- select pin synchroniser ----------------
	mnpb_sel_s sel_s1_q;
	mnpb_sel_s sel_s2_q;
	mnpb_sel_s sel_s3_q;
	mnpb_sel_s sel_q;
	mnpb_sel_s sel_d;

	// accept a change once stages two and three agree
	always_comb begin
		sel_d = sel_q;
		if (sel_s2_q == sel_s3_q) begin
			sel_d = sel_s3_q;
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			sel_s1_q <= `MNPB_SEL_RST;
			sel_s2_q <= `MNPB_SEL_RST;
			sel_s3_q <= `MNPB_SEL_RST;
			sel_q    <= `MNPB_SEL_RST;
		end else begin
			sel_s1_q <= SELECT;
			sel_s2_q <= sel_s1_q;
			sel_s3_q <= sel_s2_q;
			sel_q    <= sel_d;
		end
	end

	// ---------------- observation window ----------------
	logic [31:0] win_q;
	logic [31:0] win_d;
	logic [15:0] peak_q;
	logic [15:0] peak_d;
	logic        zc_q;
	logic        zc_d;
	logic        prev_neg_q;
	logic        prev_neg_d;
	logic        win_end;
	logic [15:0] v_mag;

	// peak and crossing flag restart at each window start
	always_comb begin
		win_end = (win_q == WIN_LAST);
		v_mag = mag16(SAMPLE.voltage_channel);
		win_d = win_end ? 32'h0 : win_q + 32'h1;
		peak_d = win_end ? 16'h0 : peak_q;
		zc_d = win_end ? 1'b0 : zc_q;
		prev_neg_d = prev_neg_q;
		if (SAMPLE_VALID) begin
			if (v_mag > peak_d) begin
				peak_d = v_mag;
			end
			if (SAMPLE.voltage_channel[15] != prev_neg_q) begin
				zc_d = 1'b1; // sign change seen
			end
			prev_neg_d = SAMPLE.voltage_channel[15];
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			win_q      <= 32'h0;
			peak_q     <= 16'h0;
			zc_q       <= 1'b0;
			prev_neg_q <= 1'b0;
		end else begin
			win_q      <= win_d;
			peak_q     <= peak_d;
			zc_q       <= zc_d;
			prev_neg_q <= prev_neg_d;
		end
	end

	// ---------------- mode decision ----------------
	mnpb_mode_e mode_q;
	mnpb_mode_e mode_d;
	mnpb_mode_e bill_q;
	mnpb_mode_e bill_d;
	logic       alarm_q;
	logic       alarm_d;

	// decided from the finished window; billing follows at next sample
	always_comb begin
		mode_d = mode_q;
		if (win_end) begin
			unique case (mode_q)
				MNPB_NORMAL: begin
					if (peak_q < PEAK_THR || !zc_q) begin
						mode_d = MNPB_MISSING;
					end
				end
				MNPB_MISSING: begin
					if (peak_q > PEAK_THR && zc_q) begin
						mode_d = MNPB_NORMAL;
					end
				end
				default: mode_d = MNPB_NORMAL;
			endcase
		end
		bill_d = SAMPLE_VALID ? mode_q : bill_q;
		alarm_d = (bill_d == MNPB_MISSING);
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			mode_q  <= MNPB_NORMAL;
			bill_q  <= MNPB_NORMAL;
			alarm_q <= 1'b0;
		end else begin
			mode_q  <= mode_d;
			bill_q  <= bill_d;
			alarm_q <= alarm_d;
		end
	end

	// ---------------- energy accumulator ----------------
	logic signed [47:0] acc_q;
	logic signed [47:0] acc_d;
	logic signed [47:0] acc_sum;
	logic signed [47:0] inc;
	logic signed [17:0] v_eff;
	logic signed [33:0] prod;
	logic [31:0]        gain_scaled;
	logic               cf_evt_q;
	logic               cf_evt_d;
	logic               reverse_power_indicator_q;
	logic               reverse_power_indicator_d;

	// product of voltage and current, or gain level times current
	always_comb begin
		gain_scaled = (32'(SAMPLE.missing_neutral_gain_in) * 32'(`MNPB_GAIN_NUM))
			>> `MNPB_GAIN_SHIFT;
		if (bill_q == MNPB_MISSING) begin
			// gain level carries the sign of the current: ampere-hour basis
			v_eff = SAMPLE.current_channel[15] ? -$signed({1'b0, gain_scaled[16:0]})
				: $signed({1'b0, gain_scaled[16:0]});
		end else begin
			v_eff = 18'(SAMPLE.voltage_channel);
		end
		prod = v_eff * 34'(SAMPLE.current_channel);
		inc = 48'(prod) <<< cf_shift(sel_q);
		acc_sum = SAMPLE_VALID ? acc_q + inc : acc_q;
		acc_d = acc_sum;
		cf_evt_d = 1'b0;
		reverse_power_indicator_d = reverse_power_indicator_q;
		if (acc_sum >= THR_POS) begin
			acc_d = acc_sum - THR_POS;
			cf_evt_d = 1'b1;
			reverse_power_indicator_d = 1'b0;
		end else if (acc_sum <= -THR_POS) begin
			acc_d = acc_sum + THR_POS;
			cf_evt_d = 1'b1;
			reverse_power_indicator_d = 1'b1;
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			acc_q    <= 48'sh0;
			cf_evt_q <= 1'b0;
			reverse_power_indicator_q   <= `MNPB_REVERSE_POWER_INDICATOR_RST;
		end else begin
			acc_q    <= acc_d;
			cf_evt_q <= cf_evt_d;
			reverse_power_indicator_q   <= reverse_power_indicator_d;
		end
	end

	// ---------------- billing divider ----------------
	logic [11:0] div_q;
	logic [11:0] div_d;
	logic        side_q;
	logic        side_d;
	logic        fa_q;
	logic        fa_d;
	logic        fb_q;
	logic        fb_d;

	// one billing pulse per ratio calibration pulses, alternating a and b
	always_comb begin
		div_d = div_q;
		side_d = side_q;
		fa_d = 1'b0;
		fb_d = 1'b0;
		if (cf_evt_q) begin
			if (div_q >= cf_ratio(sel_q) - 12'h1) begin
				div_d = 12'h0;
				side_d = ~side_q;
				fa_d = ~side_q;
				fb_d = side_q;
			end else begin
				div_d = div_q + 12'h1;
			end
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			div_q  <= 12'h0;
			side_q <= 1'b0;
			fa_q   <= 1'b0;
			fb_q   <= 1'b0;
		end else begin
			div_q  <= div_d;
			side_q <= side_d;
			fa_q   <= fa_d;
			fb_q   <= fb_d;
		end
	end

	// reverse indicator and alarm driven straight from their registers above
	assign REVERSE_POWER_INDICATOR = reverse_power_indicator_q;
	assign WIRING_ALARM = alarm_q;

	// ---------------- output pulse shapers ----------------
	mnpb_pulse_shaper #(
		.MAX_WIDTH_CYC(CF_WIDTH_CYC)
	) u_cf (
		.clk    (CLK),
		.rst    (SYS_RST),
		.trig   (cf_evt_q),
		.pulse_q(CALIBRATION_PULSE_OUT)
	);

	mnpb_pulse_shaper #(
		.MAX_WIDTH_CYC(CF_WIDTH_CYC)
	) u_fa (
		.clk    (CLK),
		.rst    (SYS_RST),
		.trig   (fa_q),
		.pulse_q(BILLING_PULSE_A)
	);

	mnpb_pulse_shaper #(
		.MAX_WIDTH_CYC(CF_WIDTH_CYC)
	) u_fb (
		.clk    (CLK),
		.rst    (SYS_RST),
		.trig   (fb_q),
		.pulse_q(BILLING_PULSE_B)
	);

	// the controller counting these pulses over its own timer window is
	// outside this block

endmodule

// ===== mnpb_core_properties.sv
`timescale 1ns/1ps
module mnpb_core_properties #(
	parameter int unsigned CF_WIDTH_CYC = 8
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic SAMPLE_VALID,
	input wire logic CALIBRATION_PULSE_OUT,
	input wire logic BILLING_PULSE_A,
	input wire logic BILLING_PULSE_B,
	input wire logic REVERSE_POWER_INDICATOR,
	input wire logic WIRING_ALARM
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	logic [31:0] cf_len_q;
	logic        a_last_q;

	// calibration pulse length and last billing output
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			cf_len_q <= '0;
			a_last_q <= 1'b0;
		end else begin
			cf_len_q <= CALIBRATION_PULSE_OUT ? cf_len_q + 1 : '0;
			if ($rose(BILLING_PULSE_A)) begin
				a_last_q <= 1'b1;
			end else if ($rose(BILLING_PULSE_B)) begin
				a_last_q <= 1'b0;
			end
		end
	end

	a_alarm_rise: assert property ($rose(WIRING_ALARM) |-> $past(SAMPLE_VALID))
		else $error("alarm rose away from a sample");
	a_alarm_fall: assert property ($fell(WIRING_ALARM) |-> $past(SAMPLE_VALID))
		else $error("alarm fell away from a sample");
	a_reverse_power_indicator_with_cf: assert property ($changed(REVERSE_POWER_INDICATOR) |-> ##1 CALIBRATION_PULSE_OUT)
		else $error("direction changed without a pulse");
	a_cf_after_sample: assert property ($rose(CALIBRATION_PULSE_OUT) |-> $past(SAMPLE_VALID, 2))
		else $error("pulse without a sample");
	a_cf_width_cap: assert property (cf_len_q <= CF_WIDTH_CYC)
		else $error("calibration pulse too wide");
	a_bill_a_cf: assert property ($rose(BILLING_PULSE_A) |-> $past(CALIBRATION_PULSE_OUT))
		else $error("billing a without calibration pulse");
	a_bill_b_cf: assert property ($rose(BILLING_PULSE_B) |-> $past(CALIBRATION_PULSE_OUT))
		else $error("billing b without calibration pulse");
	a_bill_alternate: assert property (($rose(BILLING_PULSE_A) ||
		$rose(BILLING_PULSE_B)) |-> ($rose(BILLING_PULSE_A) != a_last_q))
		else $error("billing outputs did not alternate");
endmodule

bind mnpb_core mnpb_core_properties #(.CF_WIDTH_CYC(CF_WIDTH_CYC)) mnpb_core_properties_i (
	.CLK(CLK),
	.SYS_RST(SYS_RST),
	.SAMPLE_VALID(SAMPLE_VALID),
	.CALIBRATION_PULSE_OUT(CALIBRATION_PULSE_OUT),
	.BILLING_PULSE_A(BILLING_PULSE_A),
	.BILLING_PULSE_B(BILLING_PULSE_B),
	.REVERSE_POWER_INDICATOR(REVERSE_POWER_INDICATOR),
	.WIRING_ALARM(WIRING_ALARM)
);

// ===== mnpb_mcu.sv
`timescale 1ns/1ps
module mnpb_mcu (
	input  wire logic  clk,
	input  wire logic  rst,
	input  wire logic  gate,
	input  wire logic  cf,
	input  wire logic  reverse_power_indicator,
	input  wire logic  alarm,
	output logic [15:0] pulse_cnt,
	output logic [15:0] fault_cnt,
	output logic        dir
);
	logic cf_prev;
	logic gate_prev;

	// timer window counting of calibration pulses
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cf_prev <= 1'b0;
			gate_prev <= 1'b0;
			pulse_cnt <= '0;
			fault_cnt <= '0;
			dir <= 1'b0;
		end else begin
			cf_prev <= cf;
			gate_prev <= gate;
			if (gate && !gate_prev) begin
				pulse_cnt <= '0;
				fault_cnt <= '0;
			end else if (gate && cf && !cf_prev) begin
				pulse_cnt <= pulse_cnt + 16'h1;
				fault_cnt <= fault_cnt + {15'h0, alarm};
				dir <= reverse_power_indicator;
			end
		end
	end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
	import mnpb_pkg::*;
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	logic         sv = 1'b0;
	mnpb_sample_s smp = '0;
	mnpb_sel_s    sel = 3'h3;
	logic         gate = 1'b0;
	logic         cf;
	logic         ba;
	logic         bb;
	logic         reverse_power_indicator;
	logic         alarm;
	logic         dir;
	logic [15:0]  pcnt;
	logic [15:0]  fcnt;
	int           n_errors = 0;
	int           num_checks = 0;
	int           n_a = 0;
	int           n_b = 0;

	always #2 clk = ~clk;

	mnpb_core #(.WINDOW_CYC(64), .CF_WIDTH_CYC(8)) mnpb_core_i (.CLK(clk), .SYS_RST(rst),
		.SAMPLE_VALID(sv), .SAMPLE(smp), .SELECT(sel), .CALIBRATION_PULSE_OUT(cf),
		.BILLING_PULSE_A(ba), .BILLING_PULSE_B(bb), .REVERSE_POWER_INDICATOR(reverse_power_indicator),
		.WIRING_ALARM(alarm));
	mnpb_mcu mnpb_mcu_i (.clk(clk), .rst(rst), .gate(gate), .cf(cf), .reverse_power_indicator(reverse_power_indicator),
		.alarm(alarm), .pulse_cnt(pcnt), .fault_cnt(fcnt), .dir(dir));

	// billing pulses seen by the register drive
	always @(posedge ba) n_a++;
	always @(posedge bb) n_b++;

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	// one sample every 16 cycles, signs flipped on odd samples when alt
	task automatic run(input logic signed [15:0] v, input logic signed [15:0] i,
		input logic [14:0] g, input int n, input bit alt);
		for (int k = 0; k < n; k++) begin
			@(posedge clk);
			#1;
			sv = 1'b1;
			smp = {(alt && k[0]) ? -v : v, (alt && k[0]) ? -i : i, g};
			@(posedge clk);
			#1;
			sv = 1'b0;
			repeat (14) @(posedge clk);
		end
		#1;
	endtask

	task automatic meas(input logic signed [15:0] v, input logic signed [15:0] i,
		input logic [14:0] g, input int n, input bit alt, input logic [15:0] exp);
		@(posedge clk);
		#1;
		gate = 1'b1;
		run(v, i, g, n, alt);
		check("cf count", pcnt, exp);
		gate = 1'b0;
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// hang guard
	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		close_out();
	end

	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		repeat (8) @(posedge clk);
		meas(16'sd4096, 16'sd1024, 15'h0, 2048, 1'b1, 16'd2048);
		check("bill a", n_a, 1);
		check("bill b", n_b, 0);
		sel = 3'h2;
		repeat (8) @(posedge clk);
		meas(16'sd16384, 16'sd16384, 15'h0, 64, 1'b1, 16'd16);
		check("bill b", n_b, 1);
		check("reverse_power_indicator", reverse_power_indicator, 0);
		sel = 3'h0;
		repeat (8) @(posedge clk);
		meas(16'sd16384, -16'sd16384, 15'h0, 32, 1'b1, 16'd8);
		check("reverse_power_indicator", reverse_power_indicator, 1);
		sel = 3'h4;
		repeat (8) @(posedge clk);
		meas(16'sd16384, -16'sd16384, 15'h0, 16, 1'b1, 16'd8);
		sel = 3'h0;
		repeat (8) @(posedge clk);
		run(16'sd0, 16'sd0, 15'h0, 16, 1'b0);
		check("alarm", alarm, 1);
		meas(16'sd0, 16'sd16384, 15'd20868, 32, 1'b1, 16'd8);
		check("fault count", fcnt, 8);
		check("direction", dir, 0);
		meas(16'sd0, 16'sd16384, 15'd10434, 32, 1'b1, 16'd4);
		meas(16'sd0, 16'sd16384, 15'h0, 16, 1'b1, 16'd0);
		run(16'sd16384, 16'sd0, 15'h0, 16, 1'b1);
		check("alarm", alarm, 0);
		run(16'sd16384, 16'sd0, 15'h0, 16, 1'b0);
		check("alarm", alarm, 1);
		close_out();
	end
endmodule
